// file: sdbap_core.sv
// Column-access core of a two-bank synchronous DRAM: bank state, burst
// address generation, read pipeline and write path into the cell array.
// Assumes an array that returns read data one cycle after a request and
// takes writes through a valid/ready port; pins arrive asynchronously.
`timescale 1ns/1ns
`include "sdbap_cfg.svh"

module sdbap_core #(
   parameter int TRP_CYC = `SDBAP_TRP_CYC,
   parameter int FIFO_DEPTH = `SDBAP_FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [`SDBAP_ADDR_W-1:0] addr,
   input wire logic upper_byte_mask,
   input wire logic lower_byte_mask,
   input wire logic [`SDBAP_DQ_W-1:0] dq_in,
   output logic [`SDBAP_DQ_W-1:0] dq_out,
   output logic [1:0] dq_oe,
   input wire logic cas_latency3,
   input wire logic burst_interleaved,
   input wire logic [2:0] burst_len_code,
   input wire logic single_write,
   output logic arr_wr_valid,
   input wire logic arr_wr_ready,
   output logic arr_wr_bank,
   output logic [`SDBAP_ROW_W-1:0] arr_wr_row,
   output logic [`SDBAP_COL_W-1:0] arr_wr_col,
   output logic [`SDBAP_DQ_W-1:0] arr_wr_data,
   output logic [1:0] arr_wr_byte_en,
   output logic arr_rd_en,
   output logic arr_rd_bank,
   output logic [`SDBAP_ROW_W-1:0] arr_rd_row,
   output logic [`SDBAP_COL_W-1:0] arr_rd_col,
   input wire logic [`SDBAP_DQ_W-1:0] arr_rd_data,
   output logic [1:0] bank_open,
   output logic [1:0] bank_precharging,
   output logic write_dropped
);

   localparam int FW = 3 + `SDBAP_ROW_W + `SDBAP_COL_W + `SDBAP_DQ_W;
   localparam int chk_trp_m1 = TRP_CYC - 1;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [3:0] cmd_m;
   logic [3:0] cmd_s;
   logic [`SDBAP_ADDR_W-1:0] addr_m;
   logic [`SDBAP_ADDR_W-1:0] addr_s;
   logic [1:0] mask_m;
   logic [1:0] mask_s;
   logic [`SDBAP_DQ_W-1:0] dq_m;
   logic [`SDBAP_DQ_W-1:0] dq_s;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cmd_m <= 4'hf;
         cmd_s <= 4'hf;
         addr_m <= '0;
         addr_s <= '0;
         mask_m <= 2'h0;
         mask_s <= 2'h0;
         dq_m <= '0;
         dq_s <= '0;
      end else begin
         cmd_m <= {cs_n, ras_n, cas_n, we_n};
         cmd_s <= cmd_m;
         addr_m <= addr;
         addr_s <= addr_m;
         mask_m <= {upper_byte_mask, lower_byte_mask};
         mask_s <= mask_m;
         dq_m <= dq_in;
         dq_s <= dq_m;
      end
   end

   // ****************************************************************
   // Command decode
   // ****************************************************************
   logic [`SDBAP_ROW_W-1:0] bank_row [2];

   wire is_act = cmd_s == sdbap_pkg::cmd_act;
   wire is_rd = cmd_s == sdbap_pkg::cmd_read;
   wire is_wr = cmd_s == sdbap_pkg::cmd_write;
   wire is_pre = cmd_s == sdbap_pkg::cmd_pre;
   wire is_stop = cmd_s == sdbap_pkg::cmd_stop;
   wire row_bank_flag = addr_s[`SDBAP_BANK_SELECT_BIT];
   wire column_autoprecharge_flag = addr_s[`SDBAP_PRECHARGE_SCOPE_BIT];
   // Reads and writes to a bank that is not open are dropped silently
   wire rd_ok = is_rd & bank_open[row_bank_flag];
   wire wr_ok = is_wr & bank_open[row_bank_flag];
   wire col_ok = rd_ok | wr_ok;

   wire mode_full = burst_len_code == `SDBAP_BL_FULL;
   wire [8:0] mode_len = mode_full ? `SDBAP_PAGE_LEN : (9'h1 << burst_len_code[1:0]);
   wire wr_single = is_wr & single_write;
   wire [8:0] cmd_len = wr_single ? 9'h1 : mode_len;
   wire cmd_full = mode_full & ~wr_single;
   wire cmd_ap = col_ok & column_autoprecharge_flag & ~cmd_full;

   // ****************************************************************
   // Burst engine
   // ****************************************************************
   logic bst_rd;
   logic bst_wr;
   logic bst_full;
   logic bst_il;
   logic bst_ap;
   logic bst_bank;
   logic [`SDBAP_ROW_W-1:0] bst_row;
   logic [7:0] bst_start;
   logic [8:0] bst_cnt;
   logic [8:0] bst_len;

   function automatic logic [7:0] beat_col(input logic [7:0] start, input logic [7:0] k,
                                           input logic [8:0] len, input logic il,
                                           input logic full);
      logic [7:0] m;
      logic [7:0] low;
      m = full ? 8'hff : 8'(len - 9'h1);
      low = (il & ~full) ? (start ^ k) : 8'(start + k);
      beat_col = (start & ~m) | (low & m);
   endfunction

   wire bst_busy = bst_rd | bst_wr;
   // A precharge to the burst's bank, a stop or a new column command ends it
   wire pre_hits_bst = is_pre & (column_autoprecharge_flag | (row_bank_flag == bst_bank));
   wire kill = col_ok | is_stop | pre_hits_bst;
   wire beat_live = bst_busy & ~kill;
   wire last_beat = beat_live & ~bst_full & (bst_cnt == bst_len - 9'h1);
   wire [7:0] cur_col = beat_col(bst_start, bst_cnt[7:0], bst_len, bst_il, bst_full);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bst_rd <= 1'b0;
         bst_wr <= 1'b0;
         bst_full <= 1'b0;
         bst_il <= 1'b0;
         bst_ap <= 1'b0;
         bst_bank <= 1'b0;
         bst_row <= '0;
         bst_start <= 8'h00;
         bst_cnt <= 9'h000;
         bst_len <= 9'h001;
      end else if (col_ok) begin
         bst_rd <= rd_ok & (cmd_len != 9'h1);
         bst_wr <= wr_ok & (cmd_len != 9'h1);
         bst_full <= cmd_full;
         bst_il <= burst_interleaved;
         bst_ap <= cmd_ap;
         bst_bank <= row_bank_flag;
         bst_row <= bank_row[row_bank_flag];
         bst_start <= addr_s[7:0];
         bst_cnt <= 9'h001;
         bst_len <= cmd_len;
      end else if (kill | last_beat) begin
         bst_rd <= 1'b0;
         bst_wr <= 1'b0;
      end else if (beat_live) begin
         bst_cnt <= bst_cnt + 9'h001;
      end
   end

   // Auto-precharge starts two cycles after the last beat for reads and writes
   logic [1:0] ap_trig;
   wire ap_cmd_now = cmd_ap & (cmd_len == 9'h1);
   wire ap_interrupt = bst_busy & bst_ap & col_ok & (row_bank_flag != bst_bank);
   wire ap_bst_now = bst_ap & (last_beat | ap_interrupt);
   wire [1:0] next_ap_trig = {(ap_cmd_now & row_bank_flag) | (ap_bst_now & bst_bank),
                              (ap_cmd_now & ~row_bank_flag) | (ap_bst_now & ~bst_bank)};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ap_trig <= 2'h0;
      end else begin
         ap_trig <= next_ap_trig;
      end
   end

   // ****************************************************************
   // Bank state
   // ****************************************************************
   for (genvar b = 0; b < 2; b++) begin : g_bank
      sdbap_pkg::sdbap_bank_t state;
      logic [`SDBAP_ROW_W-1:0] row;
      logic [7:0] cnt;
      wire hit_act = is_act & (row_bank_flag == 1'(b));
      wire hit_pre = (is_pre & (column_autoprecharge_flag | (row_bank_flag == 1'(b))))
                     | ap_trig[b];

      always_ff @(posedge sys_clk) begin
         if (srst) begin
            state <= sdbap_pkg::bank_idle;
            row <= '0;
            cnt <= 8'h00;
         end else begin
            case (state)
               sdbap_pkg::bank_idle: begin
                  if (hit_act) begin
                     state <= sdbap_pkg::bank_active;
                     row <= addr_s[`SDBAP_ROW_W-1:0];
                  end
               end
               sdbap_pkg::bank_active: begin
                  if (hit_pre) begin
                     state <= sdbap_pkg::bank_prech;
                     cnt <= 8'(TRP_CYC - 1);
                  end
               end
               sdbap_pkg::bank_prech: begin
                  if (cnt <= 8'h01) begin
                     state <= sdbap_pkg::bank_idle;
                  end else begin
                     cnt <= cnt - 8'h01;
                  end
               end
               default: begin
                  state <= sdbap_pkg::bank_idle;
               end
            endcase
         end
      end

      assign bank_open[b] = state == sdbap_pkg::bank_active;
      assign bank_precharging[b] = state == sdbap_pkg::bank_prech;
      assign bank_row[b] = row;
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   // Beat 0 is requested in the command cycle so that latency 2 is reachable
   assign arr_rd_en = rd_ok | (bst_rd & beat_live);
   assign arr_rd_bank = rd_ok ? row_bank_flag : bst_bank;
   assign arr_rd_row = rd_ok ? bank_row[row_bank_flag] : bst_row;
   assign arr_rd_col = rd_ok ? addr_s[7:0] : cur_col;

   logic rd_q1;
   logic hold_v;
   logic [`SDBAP_DQ_W-1:0] hold;
   logic dq_valid;
   logic oe_all;
   logic [1:0] mask_d1;

   wire next_v = cas_latency3 ? hold_v : rd_q1;
   wire [`SDBAP_DQ_W-1:0] next_d = cas_latency3 ? hold : arr_rd_data;
   wire early = cas_latency3 ? rd_q1 : arr_rd_en;
   wire next_oe = next_v | early;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_q1 <= 1'b0;
         hold_v <= 1'b0;
         hold <= '0;
         dq_valid <= 1'b0;
         dq_out <= '0;
         oe_all <= 1'b0;
         mask_d1 <= 2'h0;
         dq_oe <= 2'h0;
      end else begin
         rd_q1 <= arr_rd_en;
         hold_v <= rd_q1;
         hold <= arr_rd_data;
         dq_valid <= next_v;
         if (next_v) begin
            dq_out <= next_d;
         end
         oe_all <= next_oe;
         mask_d1 <= mask_s;
         dq_oe <= {2{next_oe}} & ~mask_d1;
      end
   end

   // ****************************************************************
   // Write path
   // ****************************************************************
   wire wr_beat = wr_ok | (bst_wr & beat_live);
   wire [1:0] wr_be = ~mask_s;
   wire push = wr_beat & (wr_be != 2'h0);
   wire w_bank = wr_ok ? row_bank_flag : bst_bank;
   wire [`SDBAP_ROW_W-1:0] w_row = wr_ok ? bank_row[row_bank_flag] : bst_row;
   wire [7:0] w_col = wr_ok ? addr_s[7:0] : cur_col;
   wire [FW-1:0] push_data = {wr_be, w_bank, w_row, w_col, dq_s};
   wire [FW-1:0] pop_data;
   wire fifo_ready;

   // Pins cannot be stalled, so a full FIFO loses the beat and flags it
   sdbap_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .srst(srst),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(push_data),
      .out_valid(arr_wr_valid),
      .out_ready(arr_wr_ready),
      .out_data(pop_data)
   );

   assign {arr_wr_byte_en, arr_wr_bank, arr_wr_row, arr_wr_col, arr_wr_data} = pop_data;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         write_dropped <= 1'b0;
      end else begin
         write_dropped <= push & ~fifo_ready;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_rd_ap4_bank0;
      rd_ok && column_autoprecharge_flag && !row_bank_flag && burst_len_code == `SDBAP_BL_4
      ##1 (!col_ok && !is_pre && !is_stop) [*3];
   endsequence

   chk_interleave_step: assert property (
      rd_ok && burst_interleaved && burst_len_code == `SDBAP_BL_4 ##1 !kill
      |-> arr_rd_col[1:0] == ($past(addr_s[1:0]) ^ 2'h1))
      else $error("interleaved column order wrong");
   chk_full_page_seq: assert property (
      rd_ok && mode_full ##1 !kill |-> arr_rd_col == $past(addr_s[7:0]) + 8'h01 && bst_rd)
      else $error("full page column order wrong");
   chk_activate_row: assert property (
      is_act && !row_bank_flag && state_idle0() |=> bank_open[0]
      && bank_row[0] == $past(addr_s[`SDBAP_ROW_W-1:0]))
      else $error("activate did not open row");
   chk_read_latency: assert property (
      rd_ok && !cas_latency3 |-> ##2 dq_valid)
      else $error("read data not at latency");
   chk_driver_turn_on: assert property (
      rd_ok && !cas_latency3 |-> ##1 oe_all ##1 dq_valid && oe_all)
      else $error("output drivers late");
   chk_read_mask_float: assert property (
      $rose(mask_s[0]) |-> ##2 !dq_oe[0])
      else $error("masked byte still driven");
   chk_write_mask_block: assert property (
      wr_beat && mask_s == 2'h3 |-> !push)
      else $error("masked write reached fifo");
   chk_read_ap_start: assert property (
      s_rd_ap4_bank0 |-> ##2 bank_precharging[0])
      else $error("read auto-precharge mistimed");
   chk_full_page_no_ap: assert property (
      col_ok && column_autoprecharge_flag && cmd_full |=> !bst_ap)
      else $error("auto-precharge on full page");
   chk_write_ap_start: assert property (
      wr_ok && single_write && column_autoprecharge_flag && !row_bank_flag
      |-> ##2 bank_precharging[0])
      else $error("write auto-precharge mistimed");
   chk_burst_restart: assert property (
      col_ok |=> bst_cnt == 9'h001 && bst_start == $past(addr_s[7:0]))
      else $error("new command did not restart burst");
   chk_precharge_both: assert property (
      is_pre && column_autoprecharge_flag && bank_open == 2'h3 |=> bank_precharging == 2'h3)
      else $error("precharge all missed a bank");
   chk_single_write: assert property (
      wr_ok && single_write |=> !bst_wr)
      else $error("single write kept bursting");
   chk_precharge_time: assert property (
      $rose(bank_precharging[0]) |-> ##chk_trp_m1 !bank_precharging[0])
      else $error("row precharge time wrong");

   function automatic logic state_idle0();
      state_idle0 = !bank_open[0] && !bank_precharging[0];
   endfunction

endmodule // sdbap_core

// file: sdbap_cfg.svh
// Address layout, mode encodings and timing counts for the column-access core.
// Included by the core and by nothing that defines the same macros.
`ifndef SDBAP_CFG_SVH
`define SDBAP_CFG_SVH

// ****************************************************************
// Address and data layout
// ****************************************************************
`define SDBAP_ADDR_W 12
`define SDBAP_ROW_W 11
`define SDBAP_COL_W 8
`define SDBAP_DQ_W 16
`define SDBAP_PRECHARGE_SCOPE_BIT 10
`define SDBAP_BANK_SELECT_BIT 11

// ****************************************************************
// Mode encodings and burst figures
// ****************************************************************
`define SDBAP_BL_FULL 3'h7
`define SDBAP_BL_4 3'h2
`define SDBAP_PAGE_LEN 9'h100
`define SDBAP_FIFO_DEPTH 8

// ****************************************************************
// Timing
// ****************************************************************
`define SDBAP_CLK_MHZ 250
`define SDBAP_TRP_NS 20
`define SDBAP_TRP_CYC ((`SDBAP_TRP_NS * `SDBAP_CLK_MHZ + 999) / 1000)
`define SDBAP_READ_MASK_DELAY 2

`endif

// file: sdbap_pkg.sv
// Types shared by the column-access core.
// Assumes nothing of its surroundings.
package sdbap_pkg;

   // Command pins {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      cmd_act = 4'h3,
      cmd_read = 4'h5,
      cmd_write = 4'h4,
      cmd_pre = 4'h2,
      cmd_stop = 4'h6,
      cmd_nop = 4'h7
   } sdbap_cmd_t;

   typedef enum logic [1:0] {
      bank_idle = 2'b00,
      bank_active = 2'b01,
      bank_prech = 2'b10
   } sdbap_bank_t;

endpackage

// file: sdbap_fifo.sv
// Write-data FIFO between the pin-side write path and the cell array.
// Assumes DEPTH is a power of two; one clock, synchronous reset.
`timescale 1ns/1ns

module sdbap_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;

   wire push = in_valid & in_ready;
   // Output register refills whenever it is empty or being taken
   wire pop = (count != '0) & (~out_valid | out_ready);

   assign in_ready = count != (AW+1)'(DEPTH);

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
         if (pop) begin
            out_data <= mem[rd_ptr];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end

endmodule // sdbap_fifo

// file: sdbap_ctrl_model.sv
// Pin-side model of the memory controller that drives the core's command pins.
// Assumes one call of drive or idle per clock cycle from the bench.
`timescale 1ns/1ns

module sdbap_ctrl_model (
   input wire logic sys_clk,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [11:0] addr,
   output logic upper_byte_mask,
   output logic lower_byte_mask,
   output logic [15:0] dq_in
);
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      addr = 12'h000;
      {upper_byte_mask, lower_byte_mask} = 2'h0;
      dq_in = 16'h0000;
   end

   // Pins change 1 ns after the edge and hold for the whole cycle
   task automatic drive(input sdbap_pkg::sdbap_cmd_t c, input logic [11:0] a,
                        input logic [15:0] d, input logic [1:0] m);
      @(posedge sys_clk);
      #1;
      {cs_n, ras_n, cas_n, we_n} = c;
      addr = a;
      {upper_byte_mask, lower_byte_mask} = m;
      dq_in = d;
   endtask

   // Released data pins toggle so a stale word never looks valid
   task automatic idle;
      drive(sdbap_pkg::cmd_nop, addr, ~dq_in, 2'h0);
   endtask

   function automatic logic [11:0] row_addr(input logic b, input logic [10:0] r);
      return {b, r};
   endfunction

   // Ignored column bits are set on purpose
   function automatic logic [11:0] col_addr(input logic b, input logic ap, input logic [7:0] c);
      return {b, ap, 2'h3, c};
   endfunction
endmodule // sdbap_ctrl_model

// file: sdbap_tb.sv
// Self-checking bench for the column-access core with a behavioural cell array.
// Assumes the controller model drives pins and the array answers one cycle later.
`timescale 1ns/1ns

module tb;
   localparam int TRP = 3;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic cas_latency3 = 1'b0;
   logic burst_interleaved = 1'b0;
   logic [2:0] burst_len_code = 3'h2;
   logic single_write = 1'b0;
   logic arr_wr_ready = 1'b1;
   logic [15:0] arr_rd_data = 16'h0000;
   logic cs_n, ras_n, cas_n, we_n, upper_byte_mask, lower_byte_mask;
   logic [11:0] addr;
   logic [15:0] dq_in, dq_out, arr_wr_data;
   logic [1:0] dq_oe, arr_wr_byte_en, bank_open, bank_precharging;
   logic arr_wr_valid, arr_wr_bank, arr_rd_en, arr_rd_bank, write_dropped;
   logic [10:0] arr_wr_row, arr_rd_row;
   logic [7:0] arr_wr_col, arr_rd_col;
   logic [10:0] row_of[2];
   logic [15:0] wq_data[$];
   logic [7:0] wq_col[$];
   logic [1:0] wq_be[$];
   logic [11:0] wq_br[$];
   int miscompares = 0;
   int total_checks = 0;

   always #2 sys_clk = ~sys_clk;

   sdbap_ctrl_model u_ctl (.sys_clk(sys_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .addr(addr), .upper_byte_mask(upper_byte_mask),
      .lower_byte_mask(lower_byte_mask), .dq_in(dq_in));

   sdbap_core #(.TRP_CYC(TRP), .FIFO_DEPTH(8)) uut (.sys_clk(sys_clk), .srst(srst),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
      .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .cas_latency3(cas_latency3),
      .burst_interleaved(burst_interleaved), .burst_len_code(burst_len_code),
      .single_write(single_write), .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
      .arr_wr_bank(arr_wr_bank), .arr_wr_row(arr_wr_row), .arr_wr_col(arr_wr_col),
      .arr_wr_data(arr_wr_data), .arr_wr_byte_en(arr_wr_byte_en), .arr_rd_en(arr_rd_en),
      .arr_rd_bank(arr_rd_bank), .arr_rd_row(arr_rd_row), .arr_rd_col(arr_rd_col),
      .arr_rd_data(arr_rd_data), .bank_open(bank_open),
      .bank_precharging(bank_precharging), .write_dropped(write_dropped));

   // ****************************************
   // Cell array model
   // ****************************************
   function automatic logic [15:0] pat(input logic b, input logic [10:0] r, input logic [7:0] c);
      return {b, r[6:0], c};
   endfunction

   always @(posedge sys_clk) begin
      arr_rd_data <= (arr_rd_en === 1'b1) ? pat(arr_rd_bank, arr_rd_row, arr_rd_col) : ~arr_rd_data;
      if (arr_wr_valid === 1'b1 && arr_wr_ready) begin
         wq_data.push_back(arr_wr_data);
         wq_col.push_back(arr_wr_col);
         wq_be.push_back(arr_wr_byte_en);
         wq_br.push_back({arr_wr_bank, arr_wr_row});
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic idles(input int n);
      repeat (n) u_ctl.idle();
   endtask

   task automatic act(input logic b, input logic [10:0] r);
      row_of[b] = r;
      u_ctl.drive(sdbap_pkg::cmd_act, u_ctl.row_addr(b, r), 16'h0000, 2'h0);
      idles(2);
   endtask

   // Cycle 0 is the first cycle the array read request is seen
   task automatic rd(input logic b, input logic ap, input logic [7:0] col, input int len,
                     input int tmax);
      int t;
      int cl;
      logic [7:0] m;
      logic [7:0] k;
      logic il;
      cl = cas_latency3 ? 3 : 2;
      m = 8'(len - 1);
      il = burst_interleaved && len < 256;
      u_ctl.drive(sdbap_pkg::cmd_read, u_ctl.col_addr(b, ap, col), 16'h0000, 2'h0);
      t = 0;
      while (arr_rd_en !== 1'b1 && t < 8) begin
         u_ctl.idle();
         t++;
      end
      check("rd_start", t < 8, 1'b1);
      for (t = 0; t < tmax; t++) begin
         k = 8'(t - cl);
         if (t == cl - 1) check("oe_on", dq_oe, 2'h3);
         if (t >= cl && t < cl + len)
            check("rd_data", dq_out, pat(b, row_of[b], il ? col ^ k : (col & ~m) | ((col + k) & m)));
         if (t == cl + len) check("oe_off", dq_oe, 2'h0);
         if (ap && t == len + 1) check("ap_start", bank_precharging[b], 1'b1);
         if (ap && t == len + TRP) check("ap_idle", {bank_open[b], bank_precharging[b]}, 2'h0);
         u_ctl.idle();
      end
   endtask

   task automatic wr(input logic [7:0] col, input logic [15:0] d0, input int n);
      wq_data.delete();
      wq_col.delete();
      wq_be.delete();
      wq_br.delete();
      u_ctl.drive(sdbap_pkg::cmd_write, u_ctl.col_addr(1'b1, 1'b0, col), d0, 2'h0);
      for (int i = 1; i < n; i++) u_ctl.drive(sdbap_pkg::cmd_nop, 12'h000, d0 + 16'(i), {1'b0, i == 1});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_reads;
      act(1'b0, 11'h2a5);
      rd(1'b0, 1'b0, 8'h05, 4, 8);
      for (int i = 0; i < 8; i++) begin
         burst_len_code = 3'(i % 4);
         burst_interleaved = (i >= 4);
         cas_latency3 = i[0] ^ i[1];
         rd(1'b0, 1'b0, 8'h35 + 8'(i), 1 << (i % 4), 14);
      end
      burst_len_code = 3'h7;
      rd(1'b0, 1'b1, 8'hfe, 256, 7);
      u_ctl.drive(sdbap_pkg::cmd_stop, 12'h000, 16'h0000, 2'h0);
      idles(6);
      check("fp_open", bank_open[0], 1'b1);
      check("fp_oe", dq_oe, 2'h0);
      $display("test reads done");
   endtask

   task automatic test_autoprecharge;
      burst_len_code = 3'h2;
      burst_interleaved = 1'b0;
      cas_latency3 = 1'b0;
      rd(1'b0, 1'b1, 8'h10, 4, 9);
      $display("test autoprecharge done");
   endtask

   task automatic test_writes;
      act(1'b1, 11'h155);
      wr(8'h02, 16'ha000, 4);
      idles(8);
      check("wr_count", wq_data.size(), 16'h4);
      for (int k = 0; k < 4 && k < wq_data.size(); k++) begin
         check("wr_col", wq_col[k], 8'((2 + k) % 4));
         check("wr_data", wq_data[k], 16'ha000 + 16'(k));
         check("wr_be", wq_be[k], (k == 1) ? 2'h2 : 2'h3);
         check("wr_row", wq_br[k], {1'b1, 11'h155});
      end
      single_write = 1'b1;
      wr(8'h02, 16'hc000, 4);
      idles(8);
      check("sw_count", wq_data.size(), 16'h1);
      single_write = 1'b0;
      $display("test writes done");
   endtask

   // A write cuts a read short; masks raised two cycles ahead keep the pins free
   task automatic test_interrupt;
      wq_data.delete();
      wq_col.delete();
      act(1'b0, 11'h0c3);
      u_ctl.drive(sdbap_pkg::cmd_read, u_ctl.col_addr(1'b0, 1'b0, 8'h40), 16'h0000, 2'h0);
      repeat (2) u_ctl.drive(sdbap_pkg::cmd_nop, 12'h000, 16'h0000, 2'h3);
      u_ctl.drive(sdbap_pkg::cmd_write, u_ctl.col_addr(1'b1, 1'b0, 8'h00), 16'hd000, 2'h0);
      u_ctl.drive(sdbap_pkg::cmd_nop, 12'h000, 16'hd001, 2'h3);
      check("rw_oe", dq_oe, 2'h3);
      check("rw_word", dq_out, pat(1'b0, 11'h0c3, 8'h40));
      u_ctl.idle();
      check("rw_float", dq_oe, 2'h0);
      idles(8);
      check("rw_count", wq_data.size(), 16'h3);
      check("rw_first", wq_data[0], 16'hd000);
      check("rw_skip", wq_col[1], 8'h02);
      $display("test interrupt done");
   endtask

   task automatic test_fifo;
      logic dropped;
      dropped = 1'b0;
      burst_len_code = 3'h7;
      arr_wr_ready = 1'b0;
      wr(8'hfc, 16'hb000, 12);
      u_ctl.drive(sdbap_pkg::cmd_stop, 12'h000, 16'h0000, 2'h0);
      for (int i = 0; i < 6; i++) begin
         dropped |= write_dropped === 1'b1;
         u_ctl.idle();
      end
      arr_wr_ready = 1'b1;
      idles(20);
      check("dropped", dropped, 1'b1);
      check("fifo_count", wq_data.size(), 16'h9);
      if (wq_data.size() > 4) check("fp_wrap", wq_col[4], 8'h00);
      burst_len_code = 3'h2;
      $display("test fifo done");
   endtask

   task automatic test_precharge;
      act(1'b0, 11'h011);
      u_ctl.drive(sdbap_pkg::cmd_pre, 12'h400, 16'h0000, 2'h0);
      idles(TRP + 3);
      check("pre_all", {bank_open, bank_precharging}, 4'h0);
      act(1'b0, 11'h011);
      act(1'b1, 11'h022);
      u_ctl.drive(sdbap_pkg::cmd_pre, 12'h800, 16'h0000, 2'h0);
      idles(TRP + 3);
      check("pre_one", bank_open, 2'h1);
      u_ctl.drive(sdbap_pkg::cmd_read, u_ctl.col_addr(1'b1, 1'b0, 8'h00), 16'h0000, 2'h0);
      for (int i = 0; i < 8; i++) begin
         check("refused", arr_rd_en, 1'b0);
         u_ctl.idle();
      end
      $display("test precharge done");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #40000;
      miscompares++;
      test_done();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      idles(3);
      test_reads();
      test_autoprecharge();
      test_writes();
      test_interrupt();
      test_fifo();
      test_precharge();
      test_done();
   end
endmodule // tb
